/* File: jisp_port.sv */
// test access port with boundary register, decrypting programming path and user nonvolatile memory
//
// Overview of operation
// - test reset low forces controller reset once through the pin sync, with no link clock edge
// - undriven test reset pin reads high
// - undriven mode select reads high, steers controller
// - serial data in, undriven reads high
// - unprogrammed part keeps user I/O disabled
// - sample captures pads, shifts boundary register
// - unprogrammed sample shifts without touching I/O
// - all programming data passes the decryptor
// - memory and fabric programmed independently
// - master key stored once before encrypted data
// - authenticate programming data before any write
// - verification done inside, contents never returned
// - memory updates of 128 bits decrypted
// - soft processor variant omits decryption
// - programming over test port by programmer
// - power-up puts controller in reset state
// - transitions follow mode sampled at rising edge
`timescale 1ns/10ps
module jisp_port #(
    parameter int BND_W = 16,
    parameter bit HAS_SOFT_CPU = 1'b0,
    parameter logic [31:0] IDCODE_VAL = 32'h0000_0001, // arbitrary value
    parameter logic [31:0] AUTH_TAG = 32'h5a5a_a5a5 // arbitrary value
) (
    // system
    input wire logic sys_clk,
    input wire logic reset_n,
    // test port pins, already pulled up at the pad
    input wire jisp_pkg::jisp_pins_t pins,
    output logic tdo_o,
    output logic tdo_oe,
    // user side
    input wire logic [BND_W-1:0] pads_in,
    output logic [BND_W-1:0] bnd_drive,
    output logic extest_active,
    output logic io_en,
    output logic [jisp_pkg::BLK_W-1:0] fabric_cfg,
    input wire logic [jisp_pkg::NVM_AW-1:0] nvm_addr,
    output logic [jisp_pkg::BLK_W-1:0] nvm_rdata,
    output logic auth_ok,
    output logic verify_ok
);
    localparam int DR_W = (jisp_pkg::BLK_W > BND_W) ? jisp_pkg::BLK_W : BND_W;

    // two-stage sync; the pad pull-ups make an undriven pin arrive as 1
    jisp_pkg::jisp_pins_t sync1_q, sync2_q;
    logic tck_prev_q;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // link clock parked low as it idles, so no false edge follows reset
            sync1_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
            sync2_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
            tck_prev_q <= 1'b0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            tck_prev_q <= sync2_q.tck;
        end
    end
    wire logic tck_rise = sync2_q.tck & ~tck_prev_q;
    wire logic tck_fall = ~sync2_q.tck & tck_prev_q;
    wire logic trst_act = ~sync2_q.trst_n;

    // controller
    jisp_pkg::jisp_tap_t state_q, state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            jisp_pkg::TLR: state_d = sync2_q.tms ? jisp_pkg::TLR : jisp_pkg::RTI;
            jisp_pkg::RTI: state_d = sync2_q.tms ? jisp_pkg::SEL_DR : jisp_pkg::RTI;
            jisp_pkg::SEL_DR: state_d = sync2_q.tms ? jisp_pkg::SEL_IR : jisp_pkg::CAP_DR;
            jisp_pkg::CAP_DR: state_d = sync2_q.tms ? jisp_pkg::EXIT1_DR : jisp_pkg::SHIFT_DR;
            jisp_pkg::SHIFT_DR: state_d = sync2_q.tms ? jisp_pkg::EXIT1_DR : jisp_pkg::SHIFT_DR;
            jisp_pkg::EXIT1_DR: state_d = sync2_q.tms ? jisp_pkg::UPD_DR : jisp_pkg::PAUSE_DR;
            jisp_pkg::PAUSE_DR: state_d = sync2_q.tms ? jisp_pkg::EXIT2_DR : jisp_pkg::PAUSE_DR;
            jisp_pkg::EXIT2_DR: state_d = sync2_q.tms ? jisp_pkg::UPD_DR : jisp_pkg::SHIFT_DR;
            jisp_pkg::UPD_DR: state_d = sync2_q.tms ? jisp_pkg::SEL_DR : jisp_pkg::RTI;
            jisp_pkg::SEL_IR: state_d = sync2_q.tms ? jisp_pkg::TLR : jisp_pkg::CAP_IR;
            jisp_pkg::CAP_IR: state_d = sync2_q.tms ? jisp_pkg::EXIT1_IR : jisp_pkg::SHIFT_IR;
            jisp_pkg::SHIFT_IR: state_d = sync2_q.tms ? jisp_pkg::EXIT1_IR : jisp_pkg::SHIFT_IR;
            jisp_pkg::EXIT1_IR: state_d = sync2_q.tms ? jisp_pkg::UPD_IR : jisp_pkg::PAUSE_IR;
            jisp_pkg::PAUSE_IR: state_d = sync2_q.tms ? jisp_pkg::EXIT2_IR : jisp_pkg::PAUSE_IR;
            jisp_pkg::EXIT2_IR: state_d = sync2_q.tms ? jisp_pkg::UPD_IR : jisp_pkg::SHIFT_IR;
            jisp_pkg::UPD_IR: state_d = sync2_q.tms ? jisp_pkg::SEL_DR : jisp_pkg::RTI;
            default: state_d = jisp_pkg::TLR;
        endcase
    end
    // the test reset acts on level, with no clock edge from the link needed
    always_ff @(posedge sys_clk) begin
        if (!reset_n || trst_act) state_q <= jisp_pkg::TLR;
        else if (tck_rise) state_q <= state_d;
    end
    wire logic do_cap = tck_rise && state_q == jisp_pkg::CAP_DR;
    wire logic do_shift = tck_rise && state_q == jisp_pkg::SHIFT_DR;
    wire logic do_upd = tck_rise && state_q == jisp_pkg::UPD_DR;

    // instruction register
    logic [jisp_pkg::IR_W-1:0] ir_sh_q, ir_q;
    always_ff @(posedge sys_clk) begin
        if (!reset_n || trst_act || state_q == jisp_pkg::TLR) begin
            ir_sh_q <= jisp_pkg::IR_CAPTURE;
            ir_q <= jisp_pkg::IR_RESET;
        end else if (tck_rise) begin
            if (state_q == jisp_pkg::CAP_IR) ir_sh_q <= jisp_pkg::IR_CAPTURE;
            else if (state_q == jisp_pkg::SHIFT_IR) ir_sh_q <= {sync2_q.tdi, ir_sh_q[jisp_pkg::IR_W-1:1]};
            else if (state_q == jisp_pkg::UPD_IR) ir_q <= ir_sh_q;
        end
    end

    // selected data register length
    logic [7:0] dr_len;
    always_comb begin
        case (ir_q)
            jisp_pkg::OP_IDCODE, jisp_pkg::OP_USERCODE: dr_len = 8'(jisp_pkg::ID_W);
            jisp_pkg::OP_SAMPLE, jisp_pkg::OP_EXTEST: dr_len = 8'(BND_W);
            jisp_pkg::OP_KEY_LOAD, jisp_pkg::OP_AUTH, jisp_pkg::OP_PROG_FABRIC,
            jisp_pkg::OP_PROG_NVM, jisp_pkg::OP_VERIFY_NVM: dr_len = 8'(jisp_pkg::BLK_W);
            default: dr_len = 8'h01;
        endcase
    end

    // key, programming state and stores
    logic [jisp_pkg::BLK_W-1:0] key_q;
    logic key_set_q, programmed_q, auth_q, verify_q;
    logic [jisp_pkg::NVM_AW-1:0] waddr_q;
    logic [jisp_pkg::BLK_W-1:0] fabric_q;
    logic [jisp_pkg::BLK_W-1:0] nvm_q [jisp_pkg::NVM_WORDS];
    logic [DR_W-1:0] dr_q, dr_shift;
    logic [jisp_pkg::BLK_W-1:0] plain;

    // stand-in cipher datapath: a keyed mask in place of the full block cipher round logic
    assign plain = HAS_SOFT_CPU ? dr_q[jisp_pkg::BLK_W-1:0] : dr_q[jisp_pkg::BLK_W-1:0] ^ key_q;
    wire logic key_ok = key_set_q || HAS_SOFT_CPU;
    wire logic fab_we = do_upd && ir_q == jisp_pkg::OP_PROG_FABRIC && auth_q && key_ok;
    wire logic nvm_we = do_upd && ir_q == jisp_pkg::OP_PROG_NVM && auth_q && key_ok;

    // data register shift path: tdi enters at the selected length
    always_comb begin
        for (int i = 0; i < DR_W; i++) begin
            if (i == int'(dr_len) - 1) dr_shift[i] = sync2_q.tdi;
            else if (i < int'(dr_len) - 1) dr_shift[i] = dr_q[i+1];
            else dr_shift[i] = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dr_q <= '0;
        end else if (do_cap) begin
            case (ir_q)
                jisp_pkg::OP_IDCODE: dr_q <= DR_W'(IDCODE_VAL);
                // input buffers are off while unprogrammed, so the capture is not meaningful
                jisp_pkg::OP_SAMPLE, jisp_pkg::OP_EXTEST: dr_q <= DR_W'(pads_in & {BND_W{io_en}});
                // only the pass flag leaves the part, never the stored words
                jisp_pkg::OP_VERIFY_NVM: dr_q <= '0;
                default: dr_q <= '0;
            endcase
        end else if (do_shift) begin
            dr_q <= dr_shift;
        end
    end

    // boundary update latch; pins follow it only under extest on a programmed part
    always_ff @(posedge sys_clk) begin
        if (!reset_n) bnd_drive <= '0;
        else if (do_upd && (ir_q == jisp_pkg::OP_SAMPLE || ir_q == jisp_pkg::OP_EXTEST)) bnd_drive <= dr_q[BND_W-1:0];
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) extest_active <= 1'b0;
        else extest_active <= (ir_q == jisp_pkg::OP_EXTEST) && programmed_q;
    end

    // master key: written once, then locked
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            key_q <= '0;
            key_set_q <= 1'b0;
        end else if (do_upd && ir_q == jisp_pkg::OP_KEY_LOAD && !key_set_q) begin
            key_q <= dr_q[jisp_pkg::BLK_W-1:0];
            key_set_q <= 1'b1;
        end
    end

    // authentication of the incoming file and write address
    always_ff @(posedge sys_clk) begin
        if (!reset_n || trst_act) begin
            auth_q <= 1'b0;
            waddr_q <= '0;
        end else if (do_upd && ir_q == jisp_pkg::OP_AUTH) begin
            auth_q <= key_ok && plain[jisp_pkg::BLK_W-1 -: jisp_pkg::AUTH_W] == AUTH_TAG;
            waddr_q <= '0;
        end else if (nvm_we || (do_upd && ir_q == jisp_pkg::OP_VERIFY_NVM)) begin
            waddr_q <= waddr_q + 1'b1;
        end
    end

    // fabric and memory stores are written by separate instructions
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fabric_q <= '0;
            programmed_q <= 1'b0;
        end else if (fab_we) begin
            fabric_q <= plain;
            programmed_q <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            for (int w = 0; w < jisp_pkg::NVM_WORDS; w++) nvm_q[w] <= '0;
        end else if (nvm_we) begin
            nvm_q[waddr_q] <= plain;
        end
    end
    // verify compares on chip; a mismatch stays until the next authentication
    always_ff @(posedge sys_clk) begin
        if (!reset_n || (do_upd && ir_q == jisp_pkg::OP_AUTH)) verify_q <= 1'b1;
        else if (do_upd && ir_q == jisp_pkg::OP_VERIFY_NVM && plain != nvm_q[waddr_q]) verify_q <= 1'b0;
    end

    // user-facing outputs
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            io_en <= 1'b0;
            fabric_cfg <= '0;
            nvm_rdata <= '0;
            auth_ok <= 1'b0;
            verify_ok <= 1'b0;
        end else begin
            io_en <= programmed_q;
            fabric_cfg <= fabric_q;
            nvm_rdata <= nvm_q[nvm_addr];
            auth_ok <= auth_q;
            verify_ok <= verify_q;
        end
    end

    // serial out moves on the falling edge so the far side samples it stable
    always_ff @(posedge sys_clk) begin
        if (!reset_n || trst_act) begin
            tdo_o <= 1'b1;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_o <= (state_q == jisp_pkg::SHIFT_IR) ? ir_sh_q[0] : dr_q[0];
            tdo_oe <= state_q == jisp_pkg::SHIFT_IR || state_q == jisp_pkg::SHIFT_DR;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence upd_fab_s;
        fab_we ##1 1'b1;
    endsequence
    trst_reset_a: assert property (trst_act |=> state_q == jisp_pkg::TLR) else $error("reset pin ignored");
    tms_hold_a: assert property (tck_rise && state_q == jisp_pkg::TLR && sync2_q.tms && !trst_act
        |=> state_q == jisp_pkg::TLR) else $error("left reset with mode high");
    state_step_a: assert property (!tck_rise && !trst_act |=> $stable(state_q)) else $error("state moved off edge");
    io_off_a: assert property (!programmed_q |=> !io_en) else $error("io enabled unprogrammed");
    tdo_edge_a: assert property (!tck_fall && !trst_act |=> $stable(tdo_o) && $stable(tdo_oe))
        else $error("data out moved off falling edge");
    tdo_shift_a: assert property (tck_fall && !trst_act && state_q == jisp_pkg::RTI |=> !tdo_oe)
        else $error("data out driven outside shift");
    key_lock_a: assert property (key_set_q |=> $stable(key_q)) else $error("key rewritten");
    auth_gate_a: assert property (fab_we || nvm_we |-> auth_q) else $error("write without auth");
    fab_sep_a: assert property (upd_fab_s |-> programmed_q && $stable(nvm_q[0])) else $error("fabric write hit memory");
    nvm_sep_a: assert property (nvm_we |=> $stable(fabric_q)) else $error("memory write hit fabric");
    sample_cap_a: assert property (do_cap && ir_q == jisp_pkg::OP_SAMPLE
        |=> dr_q[BND_W-1:0] == ($past(pads_in) & {BND_W{$past(io_en)}})) else $error("bad pad capture");
    powerup_a: assert property ($rose(reset_n) |-> state_q == jisp_pkg::TLR) else $error("no reset state");
endmodule : jisp_port

/* File: jisp_pkg.sv */
// shared constants and types of the serial test and programming access port
package jisp_pkg;
    localparam int IR_W = 8;
    localparam int ID_W = 32;
    localparam int BLK_W = 128;
    localparam int NVM_BITS = 1024;
    localparam int NVM_WORDS = NVM_BITS / BLK_W;
    localparam int NVM_AW = $clog2(NVM_WORDS);
    localparam int AUTH_W = 32;
    localparam int unsigned SYS_CLK_HZ = 25000000;
    localparam int unsigned LINK_CLK_NS = 320;
    localparam int unsigned LINK_CYCLES = (LINK_CLK_NS * (SYS_CLK_HZ / 1000000)) / 1000;
    // boundary scan instructions
    localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE = 8'h01;
    localparam logic [IR_W-1:0] OP_CLAMP = 8'h05;
    localparam logic [IR_W-1:0] OP_HIGHZ = 8'h07;
    localparam logic [IR_W-1:0] OP_USERCODE = 8'h0e;
    localparam logic [IR_W-1:0] OP_IDCODE = 8'h0f;
    localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;
    // in-system programming instructions
    localparam logic [IR_W-1:0] OP_KEY_LOAD = 8'h20;
    localparam logic [IR_W-1:0] OP_AUTH = 8'h21;
    localparam logic [IR_W-1:0] OP_PROG_FABRIC = 8'h22;
    localparam logic [IR_W-1:0] OP_PROG_NVM = 8'h23;
    localparam logic [IR_W-1:0] OP_VERIFY_NVM = 8'h24;
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
    localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jisp_pins_t;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } jisp_tap_t;
endpackage : jisp_pkg

/* File: jisp_host.sv */
// programmer model that drives the test port pins from outside the device
`timescale 1ns/10ps
module jisp_host (
    // system
    input wire logic sys_clk,
    // test port pins
    output jisp_pkg::jisp_pins_t pins,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    // no pull on the data out pad, so a released pin floats
    wire logic tdo_w = tdo_oe ? tdo_o : 1'bz;
    // an unused port is parked in reset
    initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
    task automatic pulse(input logic m, input logic d, output logic o);
        @(posedge sys_clk);
        pins.tms <= m;
        pins.tdi <= d;
        pins.tck <= 1'b0;
        repeat (4) @(posedge sys_clk);
        o = tdo_w;
        pins.tck <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
    // the link clock stands still low between frames, data in goes to its pull-up level
    task automatic idle();
        @(posedge sys_clk);
        pins.tck <= 1'b0;
        pins.tdi <= 1'b1;
        // registered status outputs settle one edge after the update step
        @(negedge sys_clk);
    endtask : idle
    task automatic tms_reset();
        logic o;
        @(posedge sys_clk);
        pins.trst_n <= 1'b1;
        for (int i = 0; i < 5; i++) pulse(1'b1, 1'b1, o);
        pulse(1'b0, 1'b1, o);
        idle();
    endtask : tms_reset
    // reset with the link clock stopped, then step to idle
    task automatic trst_pulse();
        logic o;
        @(posedge sys_clk);
        pins.trst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        pins.trst_n <= 1'b1;
        pulse(1'b0, 1'b1, o);
        idle();
    endtask : trst_pulse
    // one instruction or data scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input int len, input logic [127:0] din, output logic [127:0] dout);
        logic o;
        dout = '0;
        pulse(1'b1, 1'b1, o);
        if (ir) pulse(1'b1, 1'b1, o);
        pulse(1'b0, 1'b1, o);
        pulse(1'b0, 1'b1, o);
        for (int i = 0; i < len; i++) begin
            pulse(i == len - 1, din[i], o);
            dout[i] = o;
        end
        pulse(1'b1, 1'b1, o);
        pulse(1'b0, 1'b1, o);
        idle();
    endtask : scan
endmodule : jisp_host

/* File: tb_jtag_isp_access_port.sv */
// self-checking bench for the test and programming access port
`timescale 1ns/10ps
module tb_jtag_isp_access_port;
    localparam logic [31:0] IDV = 32'h1357_9bdf; // arbitrary value
    localparam logic [31:0] TAG = 32'hc0de_0042; // arbitrary value
    localparam logic [127:0] KEY = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    localparam logic [127:0] GOOD = {TAG, 96'h0} ^ KEY;
    localparam logic [127:0] FAB = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] pads_in = 16'h0000;
    logic [jisp_pkg::NVM_AW-1:0] nvm_addr = '0;
    jisp_pkg::jisp_pins_t pins;
    logic tdo_o, tdo_oe, extest_active, io_en, auth_ok, verify_ok;
    logic [15:0] bnd_drive;
    logic [127:0] fabric_cfg, nvm_rdata, dout;
    logic auth_sc;
    int bad_count = 0;
    int cmp_count = 0;
    jisp_host host (.sys_clk(sys_clk), .pins(pins), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
    jisp_port #(.BND_W(16), .IDCODE_VAL(IDV), .AUTH_TAG(TAG)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .pins(pins), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
        .pads_in(pads_in), .bnd_drive(bnd_drive), .extest_active(extest_active), .io_en(io_en),
        .fabric_cfg(fabric_cfg), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .auth_ok(auth_ok),
        .verify_ok(verify_ok));
    // soft processor variant on the same pins: takes programming data in the clear
    jisp_port #(.BND_W(16), .HAS_SOFT_CPU(1'b1), .IDCODE_VAL(IDV), .AUTH_TAG(TAG)) DUT_SC (
        .sys_clk(sys_clk), .reset_n(reset_n), .pins(pins), .tdo_o(), .tdo_oe(),
        .pads_in(pads_in), .bnd_drive(), .extest_active(), .io_en(),
        .fabric_cfg(), .nvm_addr(nvm_addr), .nvm_rdata(), .auth_ok(auth_sc),
        .verify_ok());
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic ir(input logic [7:0] op);
        host.scan(1'b1, 8, 128'(op), dout);
        check(dout, 128'(jisp_pkg::IR_CAPTURE));
    endtask : ir
    task automatic dr(input int len, input logic [127:0] d);
        host.scan(1'b0, len, d, dout);
    endtask : dr
    function automatic logic [127:0] word(input int w);
        return {4{32'(w) ^ 32'h9e37_79b9}};
    endfunction : word
    task automatic t_reset();
        host.tms_reset();
        check(tdo_oe, 1'b0);
        dr(32, '0);
        check(dout, 128'(IDV));
        check(io_en, 1'b0);
        $display("done: reset");
    endtask : t_reset
    task automatic t_blank_sample();
        @(posedge sys_clk);
        pads_in <= 16'ha5c3;
        ir(jisp_pkg::OP_SAMPLE);
        dr(16, 128'h3cc3);
        check(dout, '0);
        check({io_en, extest_active}, 2'b00);
        $display("done: blank sample");
    endtask : t_blank_sample
    task automatic t_refuse_auth();
        ir(jisp_pkg::OP_PROG_FABRIC);
        dr(128, FAB);
        check(fabric_cfg, 128'h0);
        check(io_en, 1'b0);
        ir(jisp_pkg::OP_KEY_LOAD);
        dr(128, KEY);
        ir(jisp_pkg::OP_KEY_LOAD);
        dr(128, ~KEY);
        ir(jisp_pkg::OP_AUTH);
        dr(128, GOOD ^ {32'h1, 96'h0});
        check(auth_ok, 1'b0);
        ir(jisp_pkg::OP_AUTH);
        dr(128, {TAG, 96'h0});
        check({auth_ok, auth_sc}, 2'b01);
        ir(jisp_pkg::OP_AUTH);
        dr(128, GOOD);
        check(auth_ok, 1'b1);
        check(auth_sc, 1'b0);
        $display("done: key and auth");
    endtask : t_refuse_auth
    task automatic t_program();
        ir(jisp_pkg::OP_PROG_FABRIC);
        dr(128, FAB ^ KEY);
        check(fabric_cfg, FAB);
        check(io_en, 1'b1);
        ir(jisp_pkg::OP_AUTH);
        dr(128, GOOD);
        ir(jisp_pkg::OP_PROG_NVM);
        for (int w = 0; w < 8; w++) dr(128, word(w) ^ KEY);
        for (int w = 0; w < 8; w++) begin
            @(posedge sys_clk);
            nvm_addr <= w[2:0];
            repeat (2) @(posedge sys_clk);
            check(nvm_rdata, word(w));
        end
        check(fabric_cfg, FAB);
        ir(jisp_pkg::OP_AUTH);
        dr(128, GOOD);
        ir(jisp_pkg::OP_VERIFY_NVM);
        for (int w = 0; w < 8; w++) begin
            dr(128, word(w) ^ KEY);
            check(dout, '0);
        end
        check(verify_ok, 1'b1);
        dr(128, word(1) ^ KEY);
        check(verify_ok, 1'b0);
        $display("done: program and verify");
    endtask : t_program
    task automatic t_sample();
        ir(jisp_pkg::OP_SAMPLE);
        dr(16, 128'h3cc3);
        check(dout, 128'ha5c3);
        ir(jisp_pkg::OP_BYPASS);
        dr(2, 128'h1);
        check(dout, 128'h2);
        ir(jisp_pkg::OP_EXTEST);
        check({extest_active, bnd_drive}, 17'h13cc3);
        $display("done: sample");
    endtask : t_sample
    task automatic t_trst();
        host.trst_pulse();
        check({auth_ok, extest_active}, 2'b00);
        dr(32, '0);
        check(dout, 128'(IDV));
        ir(jisp_pkg::OP_SAMPLE);
        host.tms_reset();
        dr(32, '0);
        check(dout, 128'(IDV));
        $display("done: test reset");
    endtask : t_trst
    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        $display("[FAIL] %0t run did not finish", $time);
        complete_run();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_blank_sample();
        t_refuse_auth();
        t_program();
        t_sample();
        t_trst();
        complete_run();
    end
endmodule : tb_jtag_isp_access_port
